// ===== rtl/aes_round_map.vh
// constants for the round transform unit
`ifndef AES_ROUND_MAP_VH
`define AES_ROUND_MAP_VH

// ==========================================================
// operation select codes
`define OP_BYTE_SUBSTITUTE 4'h0
`define OP_BYTE_UNSUBSTITUTE 4'h1
`define OP_ROW_ROTATE 4'h2
`define OP_ROW_UNROTATE 4'h3
`define OP_COLUMN_MIX 4'h4
`define OP_COLUMN_UNMIX 4'h5
`define OP_WORD_SUBSTITUTE 4'h6
`define OP_CARRYLESS_MUL 4'h7

// ==========================================================
// field and table constants
`define FIELD_POLY_LOW 8'h1b
`define AFFINE_FWD_CONST 8'h63
`define AFFINE_INV_CONST 8'h05
`define MIX_COEF0 8'h02
`define MIX_COEF1 8'h03
`define MIX_COEF2 8'h01
`define MIX_COEF3 8'h01
`define UNMIX_COEF0 8'h0e
`define UNMIX_COEF1 8'h0b
`define UNMIX_COEF2 8'h0d
`define UNMIX_COEF3 8'h09

// ==========================================================
// feature query bits and timing
`define FEAT_CIPHER_BIT 25
`define FEAT_CLMUL_BIT 1
`define FEAT_RESET 32'h00000000
`define RESULT_LATENCY 1

`endif

// ===== rtl/sub_table_byte.v
// one byte of forward or inverse substitution, computed from the field inverse
`timescale 1ns/1ps
module sub_table_byte (
   // control
   input wire inverse,
   // data
   input wire [7:0] byteIn,
   output reg [7:0] byteOut
);
`include "aes_round_map.vh"

   // ==========================================================
   // field arithmetic
   function [7:0] fieldMultiply;
      input [7:0] a;
      input [7:0] b;
      reg [7:0] p;
      reg [7:0] x;
      integer k;
      begin
         p = 8'h00;
         x = a;
         for (k = 0; k < 8; k = k + 1) begin
            if (b[k]) begin
               p = p ^ x;
            end
            x = x[7] ? ({x[6:0], 1'b0} ^ `FIELD_POLY_LOW) : {x[6:0], 1'b0};
         end
         fieldMultiply = p;
      end
   endfunction

   // x^254 is the multiplicative inverse, and maps zero to zero
   function [7:0] fieldInverse;
      input [7:0] a;
      reg [7:0] p;
      reg [7:0] r;
      integer k;
      begin
         p = a;
         r = 8'h01;
         for (k = 0; k < 7; k = k + 1) begin
            p = fieldMultiply(p, p);
            r = fieldMultiply(r, p);
         end
         fieldInverse = r;
      end
   endfunction

   function [7:0] rotl;
      input [7:0] a;
      input [2:0] n;
      begin
         rotl = (a << n) | (a >> (4'h8 - {1'b0, n}));
      end
   endfunction

   // ==========================================================
   // tables built from one inverse keep both directions exact mirrors
   reg [7:0] inv;
   reg [7:0] pre;
   always @* begin
      if (inverse) begin
         pre = rotl(byteIn, 3'h1) ^ rotl(byteIn, 3'h3) ^ rotl(byteIn, 3'h6)
               ^ `AFFINE_INV_CONST; // RULE_08
         inv = fieldInverse(pre);
         byteOut = inv; // RULE_07
      end else begin
         pre = byteIn;
         inv = fieldInverse(pre);
         byteOut = inv ^ rotl(inv, 3'h1) ^ rotl(inv, 3'h2) ^ rotl(inv, 3'h3)
                   ^ rotl(inv, 3'h4) ^ `AFFINE_FWD_CONST; // RULE_02
      end
   end
endmodule

// ===== rtl/carryless_mul_qword.v
// 64 x 64 carry-less multiply over GF(2)
`timescale 1ns/1ps
module carryless_mul_qword (
   // operands
   input wire [63:0] opA,
   input wire [63:0] opB,
   // product
   output reg [127:0] product
);
   integer k;
   always @* begin
      product = 128'h0;
      for (k = 0; k < 64; k = k + 1) begin
         if (opB[k]) begin
            product = product ^ ({64'h0, opA} << k); // RULE_09
         end
      end
   end
endmodule

// ===== rtl/aes_round_transform_unit.v
// round transform datapath: substitution, rotation, mixing, carry-less multiply
// ==========================================================
// What this block does
// RULE_01: forward substitution maps each of 16 bytes, high nibble row, low column
// RULE_02: forward table is the standard cipher table, 00->63, 01->7c, ff->16
// RULE_03: word substitution passes each byte of a word through table, same place
// RULE_04: unmix row 0 is xor of column bytes times 0e, 0b, 0d, 09
// RULE_05: unmix rows 1-3 rotate coefficients right by row; columns independent
// RULE_06: row unrotate keeps row 0, rotates rows 1-3 right by 1, 2, 3
// RULE_07: inverse substitution uses inverse table, 00->52, 01->09
// RULE_08: inverse substitution exactly undoes forward substitution for every byte
// RULE_09: 64x64 carry-less multiply gives 128-bit product with xor, no carries
// RULE_10: cipher-round support reported as feature bit 25; caller checks it first
// RULE_11: carry-less multiply support reported as feature bit 1; caller checks it
// RULE_12: byte multiply is carry-less modulo x^8+x^4+x^3+x+1; add is xor
// RULE_13: state is 16 little-endian bytes, element (row i, col j) at byte 4j+i
// RULE_14: row rotate keeps row 0, rotates rows 1-3 left by 1, 2, 3
// RULE_15: mix uses 02, 03, 01, 01 for row 0, rotated right per row
// RULE_16: select input chooses the function; result arrives one cycle later
`timescale 1ns/1ps
module aes_round_transform_unit (
   // clock and reset
   input wire mclk,
   input wire reset,
   // request
   input wire opValid,
   input wire [3:0] opSel,
   input wire [127:0] stateIn,
   input wire [63:0] mulB,
   // answer
   output reg resValid_q,
   output reg [127:0] result_q,
   // feature discovery
   output reg [31:0] featureQuery_q
);
`include "aes_round_map.vh"

   // ==========================================================
   // field multiply for the mixing stages
   function [7:0] fieldMultiply;
      input [7:0] a;
      input [7:0] b;
      reg [7:0] p;
      reg [7:0] x;
      integer k;
      begin
         p = 8'h00;
         x = a;
         for (k = 0; k < 8; k = k + 1) begin
            if (b[k]) begin
               p = p ^ x; // RULE_12
            end
            x = x[7] ? ({x[6:0], 1'b0} ^ `FIELD_POLY_LOW) : {x[6:0], 1'b0}; // RULE_12
         end
         fieldMultiply = p;
      end
   endfunction

   function [7:0] mixCoef;
      input [1:0] n;
      input unmix;
      begin
         case (n)
            2'h0: mixCoef = unmix ? `UNMIX_COEF0 : `MIX_COEF0;
            2'h1: mixCoef = unmix ? `UNMIX_COEF1 : `MIX_COEF1;
            2'h2: mixCoef = unmix ? `UNMIX_COEF2 : `MIX_COEF2;
            default: mixCoef = unmix ? `UNMIX_COEF3 : `MIX_COEF3;
         endcase
      end
   endfunction

   // ==========================================================
   // per-byte datapath
   wire unsub = (opSel == `OP_BYTE_UNSUBSTITUTE);
   wire [127:0] subOut;
   wire [127:0] rotOut;
   wire [127:0] unrotOut;
   wire [127:0] mixOut;
   wire [127:0] unmixOut;
   wire [127:0] mulOut;

   genvar i;
   genvar j;
   generate
      for (j = 0; j < 4; j = j + 1) begin : gCol
         for (i = 0; i < 4; i = i + 1) begin : gRow
            // element (i, j) lives in byte 4j+i
            localparam integer B = 4 * j + i; // RULE_13
            localparam integer BL = 4 * ((j + i) % 4) + i;
            localparam integer BR = 4 * ((j - i + 4) % 4) + i;
            sub_table_byte uSub (
               .inverse(unsub),
               .byteIn(stateIn[8 * B +: 8]), // RULE_01
               .byteOut(subOut[8 * B +: 8])
            );
            assign rotOut[8 * B +: 8] = stateIn[8 * BL +: 8]; // RULE_14
            assign unrotOut[8 * B +: 8] = stateIn[8 * BR +: 8]; // RULE_06
            // coefficient for input row k is base[(k - i) mod 4]: right rotation per row
            localparam integer K0 = (4 - i) % 4;
            localparam integer K1 = (5 - i) % 4;
            localparam integer K2 = (6 - i) % 4;
            localparam integer K3 = (7 - i) % 4;
            assign mixOut[8 * B +: 8] =
               fieldMultiply(mixCoef(K0[1:0], 1'b0), stateIn[8 * (4 * j) +: 8])
               ^ fieldMultiply(mixCoef(K1[1:0], 1'b0), stateIn[8 * (4 * j + 1) +: 8])
               ^ fieldMultiply(mixCoef(K2[1:0], 1'b0), stateIn[8 * (4 * j + 2) +: 8])
               ^ fieldMultiply(mixCoef(K3[1:0], 1'b0),
                  stateIn[8 * (4 * j + 3) +: 8]); // RULE_15
            assign unmixOut[8 * B +: 8] =
               fieldMultiply(mixCoef(K0[1:0], 1'b1), stateIn[8 * (4 * j) +: 8])
               ^ fieldMultiply(mixCoef(K1[1:0], 1'b1), stateIn[8 * (4 * j + 1) +: 8])
               ^ fieldMultiply(mixCoef(K2[1:0], 1'b1), stateIn[8 * (4 * j + 2) +: 8])
               ^ fieldMultiply(mixCoef(K3[1:0], 1'b1),
                  stateIn[8 * (4 * j + 3) +: 8]); // RULE_04 RULE_05
         end
      end
   endgenerate

   carryless_mul_qword uMul (
      .opA(stateIn[63:0]),
      .opB(mulB),
      .product(mulOut)
   );

   // ==========================================================
   // result select; undefined codes give zero so stale data never leaks
   reg [127:0] result_d;
   always @* begin
      case (opSel)
         `OP_BYTE_SUBSTITUTE: result_d = subOut; // RULE_01
         `OP_BYTE_UNSUBSTITUTE: result_d = subOut; // RULE_07
         `OP_ROW_ROTATE: result_d = rotOut;
         `OP_ROW_UNROTATE: result_d = unrotOut;
         `OP_COLUMN_MIX: result_d = mixOut;
         `OP_COLUMN_UNMIX: result_d = unmixOut;
         `OP_WORD_SUBSTITUTE: result_d = {96'h0, subOut[31:0]}; // RULE_03
         `OP_CARRYLESS_MUL: result_d = mulOut;
         default: result_d = 128'h0;
      endcase
   end

   // ==========================================================
   // output registers: fixed one-cycle latency
   always @(posedge mclk) begin
      if (reset) begin
         resValid_q <= 1'b0;
         result_q <= 128'h0;
         featureQuery_q <= `FEAT_RESET;
      end else begin
         resValid_q <= opValid; // RULE_16
         if (opValid) begin
            result_q <= result_d; // RULE_16
         end
         featureQuery_q <= `FEAT_RESET;
         featureQuery_q[`FEAT_CIPHER_BIT] <= 1'b1; // RULE_10
         featureQuery_q[`FEAT_CLMUL_BIT] <= 1'b1; // RULE_11
      end
   end
endmodule

// ===== sim/aes_round_transform_unit_props.sv
// assertions on the round transform unit ports
`timescale 1ns/1ps
module aes_round_transform_unit_props (
   // clock and reset
   input wire mclk,
   input wire reset,
   // request
   input wire opValid,
   input wire [3:0] opSel,
   input wire [127:0] stateIn,
   input wire [63:0] mulB,
   // answer
   input wire resValid_q,
   input wire [127:0] result_q,
   input wire [31:0] featureQuery_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_answer_follows: assert property (opValid |=> resValid_q)
      else $error("answer missing");
   a_no_stray: assert property (!opValid |=> !resValid_q)
      else $error("stray answer");
   a_result_holds: assert property (!opValid |=> $stable(result_q))
      else $error("result moved");
   a_cipher_bit: assert property (!$past(reset) |-> featureQuery_q[25])
      else $error("bit 25 clear");
   a_clmul_bit: assert property (!$past(reset) |-> featureQuery_q[1])
      else $error("bit 1 clear");
   a_rotate_rows: assert property (opValid && opSel == 4'h2 |=>
      result_q[15:0] == {$past(stateIn[47:40]), $past(stateIn[7:0])}) else $error("rotate");
   a_unrotate_row: assert property (opValid && opSel == 4'h3 |=>
      result_q[15:8] == $past(stateIn[111:104])) else $error("unrotate");
   a_word_upper: assert property (opValid && opSel == 4'h6 |=>
      result_q[127:32] == 96'h0) else $error("word upper");
   a_clmul_top: assert property (opValid && opSel == 4'h7 |=>
      result_q[127:126] == {1'b0, $past(stateIn[63]) & $past(mulB[63])}) else $error("clmul");
endmodule
bind aes_round_transform_unit aes_round_transform_unit_props props_inst (.mclk(mclk),
   .reset(reset), .opValid(opValid), .opSel(opSel), .stateIn(stateIn), .mulB(mulB),
   .resValid_q(resValid_q), .result_q(result_q), .featureQuery_q(featureQuery_q));

// ===== sim/issue_pipe.sv
// model of the instruction pipeline feeding the unit
`timescale 1ns/1ps
module issue_pipe (
   // from bench
   input wire reqValid,
   input wire [3:0] reqSel,
   input wire [127:0] reqState,
   // capability bits
   input wire [31:0] featureQuery,
   // toward unit
   output wire opValid,
   output wire [3:0] opSel,
   output wire [127:0] stateIn
);
   // never issue an operation whose capability bit is clear
   assign opValid = reqValid & featureQuery[reqSel == 4'h7 ? 1 : 25];
   assign opSel = reqSel;
   // idle operand lines carry the inverted request state so a stale capture shows up
   assign stateIn = reqValid ? reqState : ~reqState;
endmodule

// ===== sim/tb_aes_round_transform_unit.sv
// self-checking bench for the round transform unit
`timescale 1ns/1ps
module tb_aes_round_transform_unit;
   reg mclk = 0, reset = 1, reqValid = 0;
   reg [3:0] reqSel = 0;
   reg [127:0] reqState = 0;
   reg [63:0] mulB = 0;
   wire opValid, resValid_q;
   wire [3:0] opSel;
   wire [127:0] stateIn, result_q;
   wire [31:0] featureQuery_q;
   reg [7:0] sb [256], isb [256];
   logic [127:0] expq [$];
   integer miscompares = 0, compares = 0;
   always #25 mclk = ~mclk;
   issue_pipe issue_pipe_inst (.reqValid(reqValid), .reqSel(reqSel), .reqState(reqState),
      .featureQuery(featureQuery_q), .opValid(opValid), .opSel(opSel), .stateIn(stateIn));
   aes_round_transform_unit aes_round_transform_unit_inst (.mclk(mclk), .reset(reset),
      .opValid(opValid), .opSel(opSel), .stateIn(stateIn), .mulB(mulB),
      .resValid_q(resValid_q), .result_q(result_q), .featureQuery_q(featureQuery_q));
   function automatic [7:0] gm(input [7:0] a, b);
      gm = 0;
      for (int k = 0; k < 8; k++) begin
         if (b[k]) gm ^= a;
         a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
      end
   endfunction
   function automatic [127:0] ref_op(input [3:0] s, input [127:0] x, input [63:0] m);
      reg [7:0] c [4];
      ref_op = 0;
      for (int k = 0; k < 16; k++) begin
         int i = k % 4, j = k / 4;
         for (int n = 0; n < 4; n++) c[n] = x[32*j+8*((i+n)%4) +: 8];
         case (s)
            0: ref_op[8*k +: 8] = sb[x[8*k +: 8]];
            1: ref_op[8*k +: 8] = isb[x[8*k +: 8]];
            2: ref_op[8*k +: 8] = x[8*(4*((j+i)%4)+i) +: 8];
            3: ref_op[8*k +: 8] = x[8*(4*((j+4-i)%4)+i) +: 8];
            4: ref_op[8*k +: 8] = gm(c[0], 2) ^ gm(c[1], 3) ^ c[2] ^ c[3];
            5: ref_op[8*k +: 8] = gm(c[0], 14) ^ gm(c[1], 11) ^ gm(c[2], 13) ^ gm(c[3], 9);
            6: if (k < 4) ref_op[8*k +: 8] = sb[x[8*k +: 8]];
            default: ;
         endcase
      end
      if (s == 7) for (int k = 0; k < 64; k++) if (m[k]) ref_op ^= {64'h0, x[63:0]} << k;
   endfunction
   task chk(input [127:0] seen, exp, input string nm);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task issue(input [3:0] s, input [127:0] x, input [63:0] m);
      @(posedge mclk);
      reqValid <= 1;
      reqSel <= s;
      reqState <= x;
      mulB <= m;
      expq.push_back(ref_op(s, x, m));
   endtask
   task conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(negedge mclk) if (resValid_q === 1'b1) begin
      if (expq.size() == 0) chk(1, 0, "stray");
      else chk(result_q, expq.pop_front(), "result");
   end
   initial begin
      repeat (2000) @(posedge mclk);
      miscompares++;
      conclude;
   end
   initial begin
      reg [127:0] st;
      void'($urandom(32'hbadb));
      // tables from field inverse and affine map
      for (int v = 0; v < 256; v++) begin
         reg [7:0] r, b;
         r = 1;
         repeat (254) r = gm(r, v[7:0]);
         b = r ^ 8'h63;
         for (int n = 1; n < 5; n++) b ^= 8'({r, r} >> (8 - n));
         sb[v] = b;
         isb[b] = v[7:0];
      end
      // anchor the computed tables at known entries so a shared slip cannot hide
      chk(sb[8'h00], 8'h63, "sub 00");
      chk(sb[8'h01], 8'h7c, "sub 01");
      chk(sb[8'hff], 8'h16, "sub ff");
      chk(isb[8'h00], 8'h52, "unsub 00");
      chk(isb[8'h01], 8'h09, "unsub 01");
      repeat (12) @(posedge mclk);
      reset <= 0;
      @(posedge mclk);
      @(negedge mclk);
      chk(featureQuery_q, 32'h02000002, "features");
      // every byte value forward then back, back to back
      for (int b = 0; b < 16; b++) begin
         for (int k = 0; k < 16; k++) st[8*k +: 8] = 8'(16 * b + k);
         issue(0, st, 0);
         issue(1, ref_op(0, st, 0), 0);
      end
      for (int s = 0; s < 48; s++)
         issue(4'(s), {$urandom, $urandom, $urandom, $urandom}, {$urandom, $urandom});
      @(posedge mclk);
      reqValid <= 0;
      repeat (3) @(posedge mclk);
      issue(7, 128'h3, 64'h3);
      @(posedge mclk);
      reqValid <= 0;
      repeat (4) @(posedge mclk);
      chk(expq.size(), 0, "pending");
      conclude;
   end
endmodule
